// >>> sim/urxsr_chk.sv
`timescale 1ns/1ns
`default_nettype none
module urxsr_chk (
   input wire logic        clock,
   input wire logic        rstn,
   input wire logic        irq,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   // ==========================================================
   // helpers
   default clocking dc @(posedge clock);
   endclocking
   default disable iff (!rstn);
   function automatic logic ok(input logic [7:0] a);
      return a[1:0] == 2'h0 && a <= urxsr_pkg::ADDR_DATA;
   endfunction : ok
   sequence s_wtake;
      s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   endsequence
   sequence s_rtake;
      s_axi_arvalid && !s_axi_rvalid;
   endsequence
   // ==========================================================
   // bus and interrupt properties
   property p_wr_resp;
      s_wtake |=> s_axi_bvalid;
   endproperty
   property p_wr_bad;
      s_wtake ##0 !ok(s_axi_awaddr) |=>
         s_axi_bresp == urxsr_pkg::RESP_SLVERR;
   endproperty
   property p_rd_resp;
      s_rtake |=> s_axi_rvalid;
   endproperty
   property p_rd_bad;
      s_rtake ##0 !ok(s_axi_araddr) |=>
         s_axi_rresp == urxsr_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_b_drop;
      s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
   endproperty
   property p_aw_gate;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   property p_irq_off;
      s_wtake ##0 (s_axi_awaddr == urxsr_pkg::ADDR_ENABLE && s_axi_wstrb[0]
         && s_axi_wdata[2:0] == 3'h0) |=> !irq [*2];
   endproperty
   a_wr_resp : assert property (p_wr_resp) else $error("no write response");
   a_wr_bad  : assert property (p_wr_bad) else $error("bad write not refused");
   a_rd_resp : assert property (p_rd_resp) else $error("no read response");
   a_rd_bad  : assert property (p_rd_bad) else $error("bad read not refused");
   a_b_hold  : assert property (p_b_hold) else $error("write response dropped");
   a_r_hold  : assert property (p_r_hold) else $error("read data dropped");
   a_b_drop  : assert property (p_b_drop) else $error("write response stuck");
   a_aw_gate : assert property (p_aw_gate) else $error("write taken early");
   a_irq_off : assert property (p_irq_off) else $error("masked irq high");
endmodule : urxsr_chk
bind urxsr_top urxsr_chk chk_u (.clock, .rstn, .irq, .s_axi_awaddr,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// >>> sim/urxsr_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module urxsr_tb_top;
   typedef struct packed {
      logic [8:0]  d;
      logic        nine;
      logic        stop;
      logic [11:0] noisy;
      logic [2:0]  stat;
   } urxsr_row_t;
   localparam int BCLK = 64;
   logic        clock, rstn, irq;
   wire         rx_pin;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   int          failures, compares, n;
   urxsr_row_t  rows [8];
   urxsr_top dut_u (.clock, .rstn, .rx_pin, .irq, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   urxsr_tx_model tx_u (.clock(clock), .line(rx_pin));
   always #5 clock = ~clock;
   // ==========================================================
   // checking and closing
   task automatic stop_test;
      if (failures == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic guard;
      n++;
      if (n > 200) begin
         failures++;
         stop_test();
      end
   endtask : guard
   // ==========================================================
   // bus master
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      n = 0;
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) s_axi_bready <= 1'b1;
         guard();
      end while (!(s_axi_bvalid && s_axi_bready));
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a);
      n = 0;
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge clock);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) s_axi_rready <= 1'b1;
         guard();
      end while (!(s_axi_rvalid && s_axi_rready));
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_rd
   task automatic frame(input urxsr_row_t r);
      logic [11:0] fr;
      fr = r.nine ? {1'b1, r.stop, r.d, 1'b0}
                  : {2'h3, r.stop, r.d[7:0], 1'b0};
      repeat (BCLK / 2) @(posedge clock);
      tx_u.send(fr, BCLK, r.noisy);
   endtask : frame
   // ==========================================================
   // main sequence
   initial begin
      clock = 1'b0;
      rstn = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
      {s_axi_arvalid, s_axi_rready} = 2'h0;
      failures = 0;
      compares = 0;
      rows = '{'{9'h055, 1'b0, 1'b1, 12'h000, 3'h1},
               '{9'h1a3, 1'b1, 1'b1, 12'h000, 3'h1},
               '{9'h0aa, 1'b1, 1'b1, 12'h000, 3'h1},
               '{9'h0f0, 1'b0, 1'b0, 12'h000, 3'h5},
               '{9'h000, 1'b0, 1'b0, 12'h000, 3'h5},
               '{9'h0c6, 1'b0, 1'b1, 12'h008, 3'h3},
               '{9'h0ff, 1'b0, 1'b1, 12'h200, 3'h3},
               '{9'h05a, 1'b0, 1'b1, 12'h001, 3'h3}};
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      for (int a = 0; a <= 20; a += 4) begin
         if (a != 12) begin
            axi_rd(8'(a));
            check(rd, 32'h0);
            check(32'(rsp), 32'(urxsr_pkg::RESP_OKAY));
         end
      end
      check(32'(irq), 32'h0);
      axi_rd(8'h18);
      check(32'(rsp), 32'(urxsr_pkg::RESP_SLVERR));
      check(rd, 32'h0);
      axi_wr(8'h18, 32'h1);
      check(32'(rsp), 32'(urxsr_pkg::RESP_SLVERR));
      axi_wr(urxsr_pkg::ADDR_BAUD, 32'h4);
      axi_wr(urxsr_pkg::ADDR_ENABLE, 32'h7);
      foreach (rows[i]) begin
         axi_wr(urxsr_pkg::ADDR_CLEAR, 32'h7);
         axi_wr(urxsr_pkg::ADDR_CTRL, {30'h0, rows[i].nine, 1'b1});
         frame(rows[i]);
         axi_rd(urxsr_pkg::ADDR_STATUS);
         check(rd, 32'(rows[i].stat));
         axi_rd(urxsr_pkg::ADDR_DATA);
         check(rd, 32'(rows[i].d));
         check(32'(irq), 32'h1);
      end
      axi_wr(urxsr_pkg::ADDR_CLEAR, 32'h7);
      axi_wr(urxsr_pkg::ADDR_CTRL, 32'h1);
      tx_u.low(8);
      repeat (100) @(posedge clock);
      axi_rd(urxsr_pkg::ADDR_STATUS);
      check(rd, 32'h0);
      frame('{9'h03c, 1'b0, 1'b1, 12'h000, 3'h1});
      axi_rd(urxsr_pkg::ADDR_DATA);
      check(rd, 32'h3c);
      axi_wr(urxsr_pkg::ADDR_STATUS, 32'h0);
      axi_rd(urxsr_pkg::ADDR_STATUS);
      check(rd, 32'h1);
      axi_wr(urxsr_pkg::ADDR_ENABLE, 32'h0);
      check(32'(irq), 32'h0);
      axi_wr(urxsr_pkg::ADDR_ENABLE, 32'h1);
      check(32'(irq), 32'h1);
      axi_wr(urxsr_pkg::ADDR_CLEAR, 32'h1);
      check(32'(irq), 32'h0);
      axi_wr(urxsr_pkg::ADDR_CTRL, 32'h0);
      frame('{9'h081, 1'b0, 1'b1, 12'h000, 3'h1});
      axi_rd(urxsr_pkg::ADDR_STATUS);
      check(rd, 32'h0);
      stop_test();
   end
endmodule : urxsr_tb_top
`default_nettype wire

// >>> sim/urxsr_tx_model.sv
`timescale 1ns/1ns
`default_nettype none
module urxsr_tx_model (
   input  wire logic clock,
   output logic      line
);
   initial line = 1'b1;
   // ==========================================================
   // frame sender at an exact bit rate, one tick of noise per marked bit
   task automatic send(input logic [11:0] bits, input int bclk,
                       input logic [11:0] noisy);
      int t;
      t = bclk / 16;
      for (int i = 0; i < 12; i++) begin
         for (int c = 0; c < bclk; c++) begin
            @(posedge clock);
            line <= (noisy[i] && c >= 8 * t + t / 2 && c < 9 * t + t / 2)
                    ? ~bits[i] : bits[i];
         end
      end
   endtask : send
   // ==========================================================
   // short low glitch on an idle line
   task automatic low(input int n);
      @(posedge clock);
      line <= 1'b0;
      repeat (n) @(posedge clock);
      line <= 1'b1;
   endtask : low
endmodule : urxsr_tx_model
`default_nettype wire

// >>> src/urxsr_pkg.sv
package urxsr_pkg;
   // ==========================================================
   // register map
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_BAUD   = 8'h04;
   localparam logic [7:0] ADDR_STATUS = 8'h08;
   localparam logic [7:0] ADDR_CLEAR  = 8'h0c;
   localparam logic [7:0] ADDR_ENABLE = 8'h10;
   localparam logic [7:0] ADDR_DATA   = 8'h14;
   // ==========================================================
   // field positions
   localparam int CTRL_RX_EN   = 0;
   localparam int CTRL_NINE    = 1;
   localparam int STAT_FULL    = 0;
   localparam int STAT_NOISE   = 1;
   localparam int STAT_FRAME   = 2;
   localparam int STAT_W       = 3;
   localparam int BAUD_W       = 16;
   localparam int DATA_W       = 9;
   // ==========================================================
   // reset values
   localparam logic [1:0]        CTRL_RST   = 2'h0;
   localparam logic [BAUD_W-1:0] BAUD_RST   = 16'h0000;
   localparam logic [STAT_W-1:0] ENABLE_RST = 3'h0;
   // ==========================================================
   // oversampling slots
   localparam logic [4:0] SLOTS      = 5'h10;
   localparam logic [4:0] SLOT_FIRST = 5'h01;
   localparam logic [4:0] SLOT_V0    = 5'h03;
   localparam logic [4:0] SLOT_V1    = 5'h05;
   localparam logic [4:0] SLOT_V2    = 5'h07;
   localparam logic [4:0] SLOT_M0    = 5'h08;
   localparam logic [4:0] SLOT_M1    = 5'h09;
   localparam logic [4:0] SLOT_M2    = 5'h0a;
   // ==========================================================
   // bus responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ==========================================================
   // receiver states
   typedef enum logic [1:0] {
      URXSR_IDLE,
      URXSR_START,
      URXSR_DATA,
      URXSR_STOP
   } urxsr_state_t;
endpackage : urxsr_pkg

// >>> src/urxsr_tick.sv
`timescale 1ns/1ns
`default_nettype none
module urxsr_tick #(
   parameter int W = 16
) (
   input  wire logic         clock,
   input  wire logic         rstn,
   input  wire logic [W-1:0] divisor,
   output logic              tick
);
   // ==========================================================
   // divider: one pulse every divisor clocks, none when zero
   initial begin
      if (W < 2) $error("urxsr_tick: W too small");
   end

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic         tick_d;

   always_comb begin
      cnt_d  = cnt_q + {{(W-1){1'b0}}, 1'b1};
      tick_d = 1'b0;
      if (divisor == '0) begin
         cnt_d = '0;
      end else if (cnt_q >= divisor - {{(W-1){1'b0}}, 1'b1}) begin
         cnt_d  = '0;
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick  <= tick_d;
      end
   end
endmodule : urxsr_tick
`default_nettype wire

// >>> src/urxsr_top.sv
`timescale 1ns/1ns
`default_nettype none
module urxsr_top #(
   parameter int BAUD_W = urxsr_pkg::BAUD_W
) (
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic        rx_pin,
   output logic             irq,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   initial begin
      if (BAUD_W < 2 || BAUD_W > 32) $error("urxsr_top: bad BAUD_W");
   end

   localparam int SW = urxsr_pkg::STAT_W;
   localparam int DW = urxsr_pkg::DATA_W;

   // ==========================================================
   // register state
   logic [1:0]        ctrl_q,   ctrl_d;
   logic [BAUD_W-1:0] baud_q,   baud_d;
   logic [SW-1:0]     enable_q, enable_d;
   logic [SW-1:0]     status_register_one_q, status_register_one_d;
   logic [DW-1:0]     rbuf_q,   rbuf_d;
   logic              bvalid_q, bvalid_d;
   logic [1:0]        bresp_q,  bresp_d;
   logic              rvalid_q, rvalid_d;
   logic [1:0]        rresp_q,  rresp_d;
   logic [31:0]       rdata_q,  rdata_d;
   logic [SW-1:0]     clr_bits;
   logic [SW-1:0]     set_bits;
   logic              load_buf;
   logic [DW-1:0]     load_val;
   logic              wr_go;
   logic              rd_go;

   // ==========================================================
   // receive line synchroniser and oversample tick
   logic rx_meta_q;
   logic rx_sync_q;
   logic oversample_tick;

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rx_meta_q <= 1'b1;
         rx_sync_q <= 1'b1;
      end else begin
         rx_meta_q <= rx_pin;
         rx_sync_q <= rx_meta_q;
      end
   end

   urxsr_tick #(
      .W (BAUD_W)
   ) u_tick (
      .clock   (clock),
      .rstn    (rstn),
      .divisor (baud_q),
      .tick    (oversample_tick)
   );

   // ==========================================================
   // receiver
   urxsr_pkg::urxsr_state_t state_q, state_d;
   logic [2:0]    hist_q,  hist_d;
   logic          prev_q,  prev_d;
   logic [4:0]    slot_q,  slot_d;
   logic [1:0]    vote_q,  vote_d;
   logic [3:0]    bidx_q,  bidx_d;
   logic [DW-1:0] shift_q, shift_d;
   logic          last_q,  last_d;
   logic          smp;
   logic          fall;
   logic [1:0]    ones;
   logic          maj;
   logic          differ;
   logic [3:0]    last_idx;

   always_comb begin
      state_d  = state_q;
      hist_d   = hist_q;
      prev_d   = prev_q;
      slot_d   = slot_q;
      vote_d   = vote_q;
      bidx_d   = bidx_q;
      shift_d  = shift_q;
      last_d   = last_q;
      set_bits = '0;
      load_buf = 1'b0;
      load_val = '0;
      smp      = rx_sync_q;
      fall     = prev_q & ~rx_sync_q;
      ones     = {1'b0, vote_q[0]} + {1'b0, vote_q[1]} + {1'b0, smp};
      maj      = ones[1];
      differ   = (ones != 2'h0) && (ones != 2'h3);
      last_idx = ctrl_q[urxsr_pkg::CTRL_NINE] ? 4'h8 : 4'h7;
      if (!ctrl_q[urxsr_pkg::CTRL_RX_EN]) begin
         state_d = urxsr_pkg::URXSR_IDLE;
         hist_d  = '0;
         slot_d  = '0;
      end else if (oversample_tick) begin
         prev_d = smp;
         slot_d = slot_q + 5'h01;
         unique case (state_q)
            urxsr_pkg::URXSR_IDLE: begin
               hist_d = {hist_q[1:0], smp};
               slot_d = '0;
               if (!smp && hist_q == 3'h7) begin
                  state_d = urxsr_pkg::URXSR_START;
                  slot_d  = urxsr_pkg::SLOT_FIRST + 5'h01;
               end
            end
            urxsr_pkg::URXSR_START: begin
               if (slot_q == urxsr_pkg::SLOT_V0) vote_d[0] = smp;
               if (slot_q == urxsr_pkg::SLOT_V1) vote_d[1] = smp;
               if (slot_q == urxsr_pkg::SLOT_V2) begin
                  if (ones[1]) begin
                     state_d = urxsr_pkg::URXSR_IDLE;
                     slot_d  = '0;
                     hist_d  = '0;
                  end else if (ones == 2'h1) begin
                     set_bits[urxsr_pkg::STAT_NOISE] = 1'b1;
                  end
               end
               if ((slot_q == urxsr_pkg::SLOT_M0 ||
                    slot_q == urxsr_pkg::SLOT_M1 ||
                    slot_q == urxsr_pkg::SLOT_M2) && smp) begin
                  set_bits[urxsr_pkg::STAT_NOISE] = 1'b1;
               end
               if (slot_q == urxsr_pkg::SLOTS) begin
                  state_d = urxsr_pkg::URXSR_DATA;
                  slot_d  = urxsr_pkg::SLOT_FIRST;
                  bidx_d  = '0;
                  last_d  = 1'b0;
               end
            end
            urxsr_pkg::URXSR_DATA: begin
               if (slot_q == urxsr_pkg::SLOT_M0) vote_d[0] = smp;
               if (slot_q == urxsr_pkg::SLOT_M1) vote_d[1] = smp;
               if (slot_q == urxsr_pkg::SLOT_M2) begin
                  shift_d = {maj, shift_q[DW-1:1]};
                  last_d  = maj;
                  if (differ) set_bits[urxsr_pkg::STAT_NOISE] = 1'b1;
               end
               if (last_q && fall && slot_q < urxsr_pkg::SLOT_M0) begin
                  slot_d = urxsr_pkg::SLOT_FIRST + 5'h01;
               end
               if (slot_q == urxsr_pkg::SLOTS ||
                   (last_q && fall && slot_q > urxsr_pkg::SLOT_M2)) begin
                  slot_d = urxsr_pkg::SLOT_FIRST;
                  if (bidx_q == last_idx) begin
                     state_d = urxsr_pkg::URXSR_STOP;
                  end else begin
                     bidx_d = bidx_q + 4'h1;
                  end
               end
            end
            urxsr_pkg::URXSR_STOP: begin
               if (slot_q == urxsr_pkg::SLOT_M0) vote_d[0] = smp;
               if (slot_q == urxsr_pkg::SLOT_M1) vote_d[1] = smp;
               if (slot_q == urxsr_pkg::SLOT_M2) begin
                  load_buf = 1'b1;
                  set_bits[urxsr_pkg::STAT_FULL] = 1'b1;
                  if (!maj) begin
                     set_bits[urxsr_pkg::STAT_FRAME] = 1'b1;
                  end
                  if (differ) set_bits[urxsr_pkg::STAT_NOISE] = 1'b1;
                  if (ctrl_q[urxsr_pkg::CTRL_NINE]) begin
                     load_val = shift_q;
                  end else begin
                     load_val = {1'b0, shift_q[DW-1:1]};
                  end
                  if (!maj && load_val == '0) begin
                     load_val = '0;
                  end
                  state_d = urxsr_pkg::URXSR_IDLE;
                  hist_d  = '0;
                  slot_d  = '0;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_q <= urxsr_pkg::URXSR_IDLE;
         hist_q  <= '0;
         prev_q  <= 1'b1;
         slot_q  <= '0;
         vote_q  <= '0;
         bidx_q  <= '0;
         shift_q <= '0;
         last_q  <= 1'b0;
      end else begin
         state_q <= state_d;
         hist_q  <= hist_d;
         prev_q  <= prev_d;
         slot_q  <= slot_d;
         vote_q  <= vote_d;
         bidx_q  <= bidx_d;
         shift_q <= shift_d;
         last_q  <= last_d;
      end
   end

   // ==========================================================
   // bus slave and status
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
      end
      return r;
   endfunction : merge

   assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
   assign rd_go         = s_axi_arvalid & ~rvalid_q;
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_arready = rd_go;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;
   assign irq           = |(status_register_one_q & enable_q);

   always_comb begin
      logic [31:0] m;
      m        = '0;
      ctrl_d   = ctrl_q;
      baud_d   = baud_q;
      enable_d = enable_q;
      clr_bits = '0;
      bvalid_d = bvalid_q & ~s_axi_bready;
      bresp_d  = bresp_q;
      rvalid_d = rvalid_q & ~s_axi_rready;
      rresp_d  = rresp_q;
      rdata_d  = rdata_q;
      rbuf_d   = load_buf ? load_val : rbuf_q;
      if (wr_go) begin
         bvalid_d = 1'b1;
         bresp_d  = urxsr_pkg::RESP_OKAY;
         unique case (s_axi_awaddr)
            urxsr_pkg::ADDR_CTRL: begin
               m      = merge({30'h0, ctrl_q}, s_axi_wdata, s_axi_wstrb);
               ctrl_d = m[1:0];
            end
            urxsr_pkg::ADDR_BAUD: begin
               m      = merge({{(32-BAUD_W){1'b0}}, baud_q},
                              s_axi_wdata, s_axi_wstrb);
               baud_d = m[BAUD_W-1:0];
            end
            urxsr_pkg::ADDR_ENABLE: begin
               m        = merge({29'h0, enable_q}, s_axi_wdata, s_axi_wstrb);
               enable_d = m[SW-1:0];
            end
            urxsr_pkg::ADDR_CLEAR: begin
               if (s_axi_wstrb[0]) clr_bits = s_axi_wdata[SW-1:0];
            end
            urxsr_pkg::ADDR_STATUS, urxsr_pkg::ADDR_DATA: begin
            end
            default: bresp_d = urxsr_pkg::RESP_SLVERR;
         endcase
      end
      status_register_one_d = (status_register_one_q & ~clr_bits) | set_bits;
      if (rd_go) begin
         rvalid_d = 1'b1;
         rresp_d  = urxsr_pkg::RESP_OKAY;
         unique case (s_axi_araddr)
            urxsr_pkg::ADDR_CTRL:   rdata_d = {30'h0, ctrl_q};
            urxsr_pkg::ADDR_BAUD:   rdata_d = {{(32-BAUD_W){1'b0}}, baud_q};
            urxsr_pkg::ADDR_STATUS: rdata_d = {29'h0, status_register_one_q};
            urxsr_pkg::ADDR_CLEAR:  rdata_d = '0;
            urxsr_pkg::ADDR_ENABLE: rdata_d = {29'h0, enable_q};
            urxsr_pkg::ADDR_DATA:   rdata_d = {23'h0, rbuf_q};
            default: begin
               rdata_d = '0;
               rresp_d = urxsr_pkg::RESP_SLVERR;
            end
         endcase
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ctrl_q                <= urxsr_pkg::CTRL_RST;
         baud_q                <= BAUD_W'(urxsr_pkg::BAUD_RST);
         enable_q              <= urxsr_pkg::ENABLE_RST;
         status_register_one_q <= '0;
         rbuf_q                <= '0;
         bvalid_q              <= 1'b0;
         bresp_q               <= urxsr_pkg::RESP_OKAY;
         rvalid_q              <= 1'b0;
         rresp_q               <= urxsr_pkg::RESP_OKAY;
         rdata_q               <= '0;
      end else begin
         ctrl_q                <= ctrl_d;
         baud_q                <= baud_d;
         enable_q              <= enable_d;
         status_register_one_q <= status_register_one_d;
         rbuf_q                <= rbuf_d;
         bvalid_q              <= bvalid_d;
         bresp_q               <= bresp_d;
         rvalid_q              <= rvalid_d;
         rresp_q               <= rresp_d;
         rdata_q               <= rdata_d;
      end
   end
endmodule : urxsr_top
`default_nettype wire
